// ### core/fopc_core.sv
/*
 fifo core with offset programming, port enable decode, mailboxes and flags.
 assumes both ports are timed on CLK; every pin passes fopc_sync first.
*/
`timescale 1ns/1ps
`default_nettype none
module fopc_core (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic MASTER_RESET_N,
   input wire logic PRESET_PARALLEL_SELECT_N,
   input wire logic FLAG_SELECT_HI_SHIFT_STROBE,
   input wire logic FLAG_SELECT_LO_SERIAL_IN,
   input wire logic FALL_THROUGH_MODE_N,
   input wire fopc_pkg::fopc_port_ctrl_type PORT_A_CTRL,
   input wire logic [fopc_pkg::DATA_W-1:0] PORT_A_DATA_IN,
   output logic [fopc_pkg::DATA_W-1:0] PORT_A_DATA_OUT,
   output logic PORT_A_DATA_OE,
   input wire fopc_pkg::fopc_port_ctrl_type PORT_B_CTRL,
   input wire logic [fopc_pkg::DATA_W-1:0] PORT_B_DATA_IN,
   output logic [fopc_pkg::DATA_W-1:0] PORT_B_DATA_OUT,
   output logic PORT_B_DATA_OE,
   output logic WRITE_SIDE_FLAG,
   output logic READ_SIDE_FLAG,
   output logic ALMOST_EMPTY_FLAG_N,
   output logic ALMOST_FULL_FLAG_N,
   output logic MAIL_ONE_FULL_N,
   output logic MAIL_TWO_FULL_N
);
   import fopc_pkg::*;

   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_out;
   logic mrst_n_s;
   logic ppsel_n_s;
   logic fs_hi_s;
   logic fs_lo_s;
   logic fall_through_mode_n_s;
   fopc_port_ctrl_type a_s;
   fopc_port_ctrl_type b_s;
   logic [DATA_W-1:0] a_din_s;
   logic [DATA_W-1:0] b_din_s;

   logic mrst_prev_reg;
   logic cfg_rise;
   fopc_prog_state_type prog_reg;
   logic [OFS_W-1:0] empty_ofs_reg;
   logic [OFS_W-1:0] full_ofs_reg;
   logic [19:0] ser_sr_reg;
   logic [19:0] ser_sr_next;
   logic [4:0] ser_cnt_reg;
   logic [1:0] ready_cnt_reg;
   logic fall_through_mode_reg;

   logic [DATA_W-1:0] mem [0:1023];
   logic [ADDR_W-1:0] wptr_reg;
   logic [ADDR_W-1:0] rptr_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [DATA_W-1:0] out_reg;
   logic ovalid_reg;
   logic ovalid_next;
   logic [DATA_W-1:0] mail1_reg;
   logic [DATA_W-1:0] mail2_reg;

   logic a_wr_cyc;
   logic a_fifo_wr;
   logic a_mail1_wr;
   logic a_mail2_rd;
   logic b_rd_cyc;
   logic b_fifo_rd;
   logic b_mail1_rd;
   logic b_mail2_wr;
   logic in_parallel;
   logic mem_wr;
   logic load_out;
   logic accepts;

   // pins and data are synchronised together so they stay aligned
   assign sync_in = {MASTER_RESET_N, PRESET_PARALLEL_SELECT_N, FLAG_SELECT_HI_SHIFT_STROBE,
                     FLAG_SELECT_LO_SERIAL_IN, FALL_THROUGH_MODE_N, PORT_A_CTRL,
                     PORT_A_DATA_IN, PORT_B_CTRL, PORT_B_DATA_IN};

   fopc_sync #(
      .W(SYNC_W)
   ) u_sync (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .D(sync_in),
      .Q(sync_out)
   );

   assign {mrst_n_s, ppsel_n_s, fs_hi_s, fs_lo_s, fall_through_mode_n_s, a_s, a_din_s, b_s, b_din_s} = sync_out;

   assign cfg_rise = mrst_n_s & ~mrst_prev_reg;

   // port enable decode; nothing happens while master reset is held
   assign a_wr_cyc = mrst_n_s & ~a_s.sel_n & a_s.direction & a_s.strobe;
   assign a_fifo_wr = a_wr_cyc & ~a_s.mail_select & WRITE_SIDE_FLAG;
   assign a_mail1_wr = a_wr_cyc & a_s.mail_select;
   assign a_mail2_rd = mrst_n_s & ~a_s.sel_n & ~a_s.direction & a_s.strobe
                       & a_s.mail_select;
   assign b_rd_cyc = mrst_n_s & ~b_s.sel_n & b_s.direction & b_s.strobe;
   assign b_fifo_rd = b_rd_cyc & ~b_s.mail_select & READ_SIDE_FLAG;
   assign b_mail1_rd = b_rd_cyc & b_s.mail_select;
   // write direction with mail select low has no function on port b
   assign b_mail2_wr = mrst_n_s & ~b_s.sel_n & ~b_s.direction & b_s.strobe
                       & b_s.mail_select;

   assign in_parallel = (prog_reg == PROG_PAR_FULL) || (prog_reg == PROG_PAR_EMPTY);
   // offset loads never reach memory
   assign mem_wr = a_fifo_wr & (prog_reg == PROG_DONE);
   assign ser_sr_next = {ser_sr_reg[18:0], fs_lo_s};

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         mrst_prev_reg <= 1'b0;
      end
      else
      begin
         mrst_prev_reg <= mrst_n_s;
      end
   end

   // timing mode is captured with the other configuration pins
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         fall_through_mode_reg <= 1'b0;
      end
      else if (cfg_rise)
      begin
         fall_through_mode_reg <= ~fall_through_mode_n_s;
      end
   end

   // offset programming: preset, parallel through port a, or serial
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         prog_reg <= PROG_WAIT;
         empty_ofs_reg <= OFS_RST;
         full_ofs_reg <= OFS_RST;
         ser_sr_reg <= SERIAL_SR_RST;
         ser_cnt_reg <= SERIAL_CNT_RST;
      end
      else if (!mrst_n_s)
      begin
         prog_reg <= PROG_WAIT;
         ser_sr_reg <= SERIAL_SR_RST;
         ser_cnt_reg <= SERIAL_CNT_RST;
      end
      else
      begin
         case (prog_reg)
            PROG_WAIT:
            begin
               if (cfg_rise)
               begin
                  if (ppsel_n_s)
                  begin
                     // at least one flag select high picks a preset
                     case ({fs_hi_s, fs_lo_s})
                        2'b11:
                        begin
                           empty_ofs_reg <= PRESET_64;
                           full_ofs_reg <= PRESET_64;
                           prog_reg <= PROG_DONE;
                        end
                        2'b10:
                        begin
                           empty_ofs_reg <= PRESET_16;
                           full_ofs_reg <= PRESET_16;
                           prog_reg <= PROG_DONE;
                        end
                        2'b01:
                        begin
                           empty_ofs_reg <= PRESET_8;
                           full_ofs_reg <= PRESET_8;
                           prog_reg <= PROG_DONE;
                        end
                        default:
                        begin
                           prog_reg <= PROG_PAR_FULL;
                        end
                     endcase
                  end
                  else if (fs_hi_s && !fs_lo_s)
                  begin
                     prog_reg <= PROG_SERIAL;
                  end
                  else
                  begin
                     // reserved: offsets kept as they were, normal operation
                     prog_reg <= PROG_DONE;
                  end
               end
            end
            PROG_PAR_FULL:
            begin
               if (a_fifo_wr)
               begin
                  full_ofs_reg <= a_din_s[OFS_W-1:0];
                  prog_reg <= PROG_PAR_EMPTY;
               end
            end
            PROG_PAR_EMPTY:
            begin
               if (a_fifo_wr)
               begin
                  empty_ofs_reg <= a_din_s[OFS_W-1:0];
                  prog_reg <= PROG_DONE;
               end
            end
            PROG_SERIAL:
            begin
               // shift strobe is active low in serial mode
               if (!fs_hi_s)
               begin
                  ser_sr_reg <= ser_sr_next;
                  ser_cnt_reg <= ser_cnt_reg + 5'h01;
                  if (ser_cnt_reg == SERIAL_LAST)
                  begin
                     full_ofs_reg <= ser_sr_next[SER_FULL_MSB:SER_FULL_LSB];
                     empty_ofs_reg <= ser_sr_next[SER_EMPTY_MSB:SER_EMPTY_LSB];
                     prog_reg <= PROG_DONE;
                  end
               end
            end
            PROG_DONE:
            begin
               prog_reg <= PROG_DONE;
            end
            default:
            begin
               prog_reg <= PROG_WAIT;
            end
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST || !mrst_n_s)
      begin
         ready_cnt_reg <= READY_CNT_RST;
      end
      else if (ready_cnt_reg != READY_DELAY)
      begin
         ready_cnt_reg <= ready_cnt_reg + 2'h1;
      end
   end

   // serial mode keeps the write flag low until the shifter is done
   assign accepts = (ready_cnt_reg == READY_DELAY) && (in_parallel || prog_reg == PROG_DONE);

   // output register load: fall-through fills an empty output on its own
   always_comb
   begin
      if (fall_through_mode_reg)
      begin
         load_out = (cnt_reg != CNT_ZERO) && (!ovalid_reg || b_fifo_rd);
      end
      else
      begin
         load_out = b_fifo_rd;
      end
      if (load_out)
      begin
         ovalid_next = 1'b1;
      end
      else if (b_fifo_rd)
      begin
         ovalid_next = 1'b0;
      end
      else
      begin
         ovalid_next = ovalid_reg;
      end
      cnt_next = cnt_reg + CNT_W'(mem_wr) - CNT_W'(load_out);
   end

   always_ff @(posedge CLK)
   begin
      if (mem_wr)
      begin
         mem[wptr_reg] <= a_din_s;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST || !mrst_n_s)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= CNT_ZERO;
         out_reg <= DATA_RST;
         ovalid_reg <= 1'b0;
      end
      else
      begin
         if (mem_wr)
         begin
            wptr_reg <= wptr_reg + 10'h001;
         end
         if (load_out)
         begin
            out_reg <= mem[rptr_reg];
            rptr_reg <= rptr_reg + 10'h001;
         end
         cnt_reg <= cnt_next;
         ovalid_reg <= ovalid_next;
      end
   end

   // flags are registered from the next count, the fall-through read flag from the next output valid, so they match the memory
   always_ff @(posedge CLK)
   begin
      if (SYS_RST || !mrst_n_s)
      begin
         WRITE_SIDE_FLAG <= 1'b0;
         READ_SIDE_FLAG <= 1'b0;
         ALMOST_EMPTY_FLAG_N <= 1'b0;
         ALMOST_FULL_FLAG_N <= 1'b1;
      end
      else
      begin
         WRITE_SIDE_FLAG <= accepts && (cnt_next < DEPTH);
         READ_SIDE_FLAG <= fall_through_mode_reg ? ovalid_next : (cnt_next != CNT_ZERO);
         ALMOST_EMPTY_FLAG_N <= cnt_next > {1'b0, empty_ofs_reg};
         ALMOST_FULL_FLAG_N <= (cnt_next + {1'b0, full_ofs_reg}) < DEPTH;
      end
   end

   // mailboxes: a new write beats a same-cycle read that would clear the flag
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         mail1_reg <= DATA_RST;
         MAIL_ONE_FULL_N <= 1'b1;
      end
      else if (!mrst_n_s)
      begin
         MAIL_ONE_FULL_N <= 1'b1;
      end
      else if (a_mail1_wr)
      begin
         mail1_reg <= a_din_s;
         MAIL_ONE_FULL_N <= 1'b0;
      end
      else if (b_mail1_rd)
      begin
         MAIL_ONE_FULL_N <= 1'b1;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         mail2_reg <= DATA_RST;
         MAIL_TWO_FULL_N <= 1'b1;
      end
      else if (!mrst_n_s)
      begin
         MAIL_TWO_FULL_N <= 1'b1;
      end
      else if (b_mail2_wr)
      begin
         mail2_reg <= b_din_s;
         MAIL_TWO_FULL_N <= 1'b0;
      end
      else if (a_mail2_rd)
      begin
         MAIL_TWO_FULL_N <= 1'b1;
      end
   end

   // data drivers; the port b direction sense is the inverse of port a
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         PORT_A_DATA_OE <= 1'b0;
         PORT_A_DATA_OUT <= DATA_RST;
         PORT_B_DATA_OE <= 1'b0;
         PORT_B_DATA_OUT <= DATA_RST;
      end
      else
      begin
         PORT_A_DATA_OE <= ~a_s.sel_n & ~a_s.direction;
         PORT_A_DATA_OUT <= mail2_reg;
         PORT_B_DATA_OE <= ~b_s.sel_n & b_s.direction;
         PORT_B_DATA_OUT <= b_s.mail_select ? mail1_reg : out_reg;
      end
   end
endmodule
`default_nettype wire

// ### core/fopc_sync.sv
/*
 two flip-flop synchroniser for a vector of pin inputs.
 assumes each bit is a level; multi-bit values must be stable around sampling.
*/
`timescale 1ns/1ps
`default_nettype none
module fopc_sync #(
   parameter int W = 1
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         meta_reg <= '0;
         Q <= '0;
      end
      else
      begin
         meta_reg <= D;
         Q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ### pkg/fopc_pkg.sv
/*
 offset programming and port control constants, types and state encodings.
 assumes one system clock; all pin inputs are synchronised before use.
*/
package fopc_pkg;

   localparam int DATA_W = 36;
   localparam int ADDR_W = 10;
   localparam int CNT_W = 11;
   localparam int OFS_W = 10;
   localparam int CTRL_W = 4;
   localparam int MODE_PINS = 5;
   localparam int SYNC_W = MODE_PINS + 2 * CTRL_W + 2 * DATA_W;

   localparam logic [CNT_W-1:0] DEPTH = 11'h400;
   localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

   // offset field positions inside the serial shifter
   localparam int SER_FULL_MSB = 19;
   localparam int SER_FULL_LSB = 10;
   localparam int SER_EMPTY_MSB = 9;
   localparam int SER_EMPTY_LSB = 0;
   localparam logic [4:0] SERIAL_LAST = 5'h13;
   localparam logic [4:0] SERIAL_CNT_RST = 5'h00;
   localparam logic [19:0] SERIAL_SR_RST = 20'h0_0000;

   localparam logic [OFS_W-1:0] PRESET_64 = 10'h040;
   localparam logic [OFS_W-1:0] PRESET_16 = 10'h010;
   localparam logic [OFS_W-1:0] PRESET_8 = 10'h008;
   localparam logic [OFS_W-1:0] OFS_RST = 10'h040;

   // write-ready delay after master reset release, in clock cycles
   localparam logic [1:0] READY_DELAY = 2'h2;
   localparam logic [1:0] READY_CNT_RST = 2'h0;

   localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;

   typedef struct packed {
      logic sel_n;
      logic direction;
      logic strobe;
      logic mail_select;
   } fopc_port_ctrl_type;

   typedef enum logic [2:0] {
      PROG_WAIT,
      PROG_PAR_FULL,
      PROG_PAR_EMPTY,
      PROG_SERIAL,
      PROG_DONE
   } fopc_prog_state_type;

endpackage

// ### testbench/fifo_offset_prog_port_ctrl_bench.sv
/*
 self-checking bench: offset modes, threshold, fifo order, refusal, mailboxes.
 assumes fopc_core, its checker and fopc_host_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module fifo_offset_prog_port_ctrl_bench;
   import fopc_pkg::*;
   logic clk, sys_rst, a_oe, b_oe, mrst_n, preset_parallel_select_n, fs_hi, fs_lo, ft_n;
   logic wflag, rflag, ae_n, af_n, m1_n, m2_n;
   fopc_port_ctrl_type a_ctrl, b_ctrl;
   logic [DATA_W-1:0] a_din, b_din, a_dout, b_dout;
   logic [DATA_W-1:0] exp_q[$];
   int err_count = 0;
   int compares = 0;
   event look;
   fopc_host_model i_fopc_host_model (.clk(clk), .a_ctrl(a_ctrl), .b_ctrl(b_ctrl),
      .a_data(a_din), .b_data(b_din), .mrst_n(mrst_n), .preset_parallel_select_n(preset_parallel_select_n), .fs_hi(fs_hi),
      .fs_lo(fs_lo), .ft_n(ft_n));
   fopc_core i_fopc_core (.CLK(clk), .SYS_RST(sys_rst), .MASTER_RESET_N(mrst_n),
      .PRESET_PARALLEL_SELECT_N(preset_parallel_select_n), .FLAG_SELECT_HI_SHIFT_STROBE(fs_hi),
      .FLAG_SELECT_LO_SERIAL_IN(fs_lo), .FALL_THROUGH_MODE_N(ft_n), .PORT_A_CTRL(a_ctrl),
      .PORT_A_DATA_IN(a_din), .PORT_A_DATA_OUT(a_dout), .PORT_A_DATA_OE(a_oe),
      .PORT_B_CTRL(b_ctrl), .PORT_B_DATA_IN(b_din), .PORT_B_DATA_OUT(b_dout),
      .PORT_B_DATA_OE(b_oe), .WRITE_SIDE_FLAG(wflag), .READ_SIDE_FLAG(rflag),
      .ALMOST_EMPTY_FLAG_N(ae_n), .ALMOST_FULL_FLAG_N(af_n), .MAIL_ONE_FULL_N(m1_n),
      .MAIL_TWO_FULL_N(m2_n));
   initial
   begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({35'h0_0000_0000, got}, {35'h0_0000_0000, exp});
   endtask
   task automatic end_sim();
      $display("%0d mismatches in %0d compares", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   function automatic logic [DATA_W-1:0] rnd();
      return DATA_W'({$urandom, $urandom});
   endfunction
   always @(look)
   begin
      if (exp_q.size() == 0)
         chkb(1'h0, 1'h1);
      else
         chk(b_dout, exp_q.pop_front());
   end
   initial
   begin
      #100000;
      err_count++;
      $display("[FAIL] %0t run did not finish in time", $time);
      end_sim();
   end
   initial
   begin
      logic [DATA_W-1:0] d;
      static logic [2:0] cfg [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h3};
      static int xs [6] = '{64, 16, 8, 3, 5, 5};
      int ft;
      void'($urandom(32'h5747_8cba));
      sys_rst = 1'h1;
      repeat (10) @(posedge clk);
      #1 sys_rst = 1'h0;
      for (int m = 0; m < 6; m++)
      begin
         ft = (m == 2);
         i_fopc_host_model.mreset(cfg[m], m != 2);
         if (m == 3)
         begin
            d = rnd();
            d[9:0] = 10'h005; // upper bits random, offsets in range
            i_fopc_host_model.pa(1'h1, 1'h0, d);
            d[9:0] = 10'h003;
            i_fopc_host_model.pa(1'h1, 1'h0, d);
         end
         if (m == 4)
         begin
            chkb(wflag, 1'h0);
            i_fopc_host_model.shift({10'h002, 10'h005});
            i_fopc_host_model.tick(1);
            chkb(wflag, 1'h0);
            i_fopc_host_model.tick(6);
         end
         chkb(wflag, 1'h1);
         // fall-through keeps one word in the output register, outside the count
         for (int i = 0; i <= xs[m] + ft; i++)
         begin
            if (i == xs[m] + ft)
            begin
               i_fopc_host_model.tick(5);
               chkb(ae_n, 1'h0);
            end
            d = rnd();
            exp_q.push_back(d);
            i_fopc_host_model.pa(1'h1, 1'h0, d);
         end
         i_fopc_host_model.tick(5);
         chkb(ae_n, 1'h1);
         for (int i = 0; i <= xs[m] + ft; i++)
         begin
            if (ft)
               ->look;
            i_fopc_host_model.pb(1'h1, 1'h0, rnd());
            i_fopc_host_model.tick(4);
            if (!ft)
               ->look;
         end
         chkb(rflag, 1'h0);
         if (!ft)
         begin
            exp_q.push_back(d);
            i_fopc_host_model.pb(1'h1, 1'h0, rnd()); // refused read
            i_fopc_host_model.tick(4);
            ->look;
         end
      end
      // fill to the brim: full offset 2 from the serial load survives the reserved reset
      for (int i = 0; i < 1024; i++)
      begin
         if (i == 1021 || i == 1022)
         begin
            i_fopc_host_model.tick(5);
            chkb(af_n, i == 1021);
         end
         d = rnd();
         exp_q.push_back(d);
         i_fopc_host_model.pa(1'h1, 1'h0, d);
      end
      i_fopc_host_model.tick(5);
      chkb(wflag, 1'h0);
      // a stored extra word would overwrite the oldest one and show on the first read
      i_fopc_host_model.pa(1'h1, 1'h0, rnd());
      i_fopc_host_model.tick(5);
      for (int i = 0; i < 1024; i++)
      begin
         i_fopc_host_model.pb(1'h1, 1'h0, rnd());
         i_fopc_host_model.tick(3);
         ->look;
      end
      i_fopc_host_model.tick(3);
      chkb(rflag, 1'h0);
      d = rnd();
      i_fopc_host_model.pa(1'h1, 1'h1, d);
      i_fopc_host_model.tick(4);
      chkb(m1_n, 1'h0);
      chkb(a_oe, 1'h0);
      exp_q.push_back(d);
      i_fopc_host_model.pb(1'h1, 1'h1, rnd());
      i_fopc_host_model.tick(4);
      ->look;
      chkb(m1_n, 1'h1);
      chkb(b_oe, 1'h1);
      d = rnd();
      i_fopc_host_model.pb(1'h0, 1'h1, d);
      i_fopc_host_model.tick(4);
      chkb(m2_n, 1'h0);
      chkb(b_oe, 1'h0);
      i_fopc_host_model.pa(1'h0, 1'h1, rnd());
      i_fopc_host_model.tick(4);
      chk(a_dout, d);
      chkb(m2_n, 1'h1);
      chkb(a_oe, 1'h1);
      end_sim();
   end
endmodule
`default_nettype wire

// ### testbench/fopc_core_sva.sv
/*
 checker for port drive enables, mailbox flags and reset flag levels.
 assumes it is bound to fopc_core and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module fopc_core_sva (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic MASTER_RESET_N,
   input wire fopc_pkg::fopc_port_ctrl_type PORT_A_CTRL,
   input wire fopc_pkg::fopc_port_ctrl_type PORT_B_CTRL,
   input wire logic PORT_A_DATA_OE,
   input wire logic PORT_B_DATA_OE,
   input wire logic WRITE_SIDE_FLAG,
   input wire logic READ_SIDE_FLAG,
   input wire logic ALMOST_EMPTY_FLAG_N,
   input wire logic ALMOST_FULL_FLAG_N,
   input wire logic MAIL_ONE_FULL_N,
   input wire logic MAIL_TWO_FULL_N
);
   import fopc_pkg::*;
   logic [3:0] up_reg;
   logic a_rd, b_rd, a_m1w, a_m2r, b_m2w, b_m1r;
   function automatic logic hit(input fopc_port_ctrl_type c, input logic dir);
      return !c.sel_n && (c.direction == dir) && c.strobe && c.mail_select;
   endfunction
   // sync stages clear on reset, so the first edges after release carry no pin history
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         up_reg <= 4'h0;
      else
         up_reg <= {up_reg[2:0], 1'b1};
   end
   assign a_rd = !PORT_A_CTRL.sel_n && !PORT_A_CTRL.direction;
   assign b_rd = !PORT_B_CTRL.sel_n && PORT_B_CTRL.direction;
   assign a_m1w = hit(PORT_A_CTRL, 1'b1);
   assign a_m2r = hit(PORT_A_CTRL, 1'b0);
   assign b_m2w = hit(PORT_B_CTRL, 1'b0);
   assign b_m1r = hit(PORT_B_CTRL, 1'b1);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   oe_port_a_a: assert property (up_reg[3] |-> PORT_A_DATA_OE == $past(a_rd, 3))
      else $error("port a drive enable wrong");
   oe_port_b_a: assert property (up_reg[3] |-> PORT_B_DATA_OE == $past(b_rd, 3))
      else $error("port b drive enable wrong");
   mail_one_set_a: assert property (up_reg[0] && a_m1w && MASTER_RESET_N
      |-> ##3 !MAIL_ONE_FULL_N) else $error("mail one flag not set");
   mail_one_clear_a: assert property (up_reg[0] && b_m1r && !a_m1w
      |-> ##3 MAIL_ONE_FULL_N) else $error("mail one flag not cleared");
   mail_two_set_a: assert property (up_reg[0] && b_m2w && MASTER_RESET_N
      |-> ##3 !MAIL_TWO_FULL_N) else $error("mail two flag not set");
   mail_two_clear_a: assert property (up_reg[0] && a_m2r && !b_m2w
      |-> ##3 MAIL_TWO_FULL_N) else $error("mail two flag not cleared");
   reset_flags_a: assert property (up_reg[0] && !MASTER_RESET_N |-> ##3
      (!WRITE_SIDE_FLAG && !READ_SIDE_FLAG && !ALMOST_EMPTY_FLAG_N && ALMOST_FULL_FLAG_N))
      else $error("flags wrong during master reset");
   empty_below_a: assert property (!READ_SIDE_FLAG |-> !ALMOST_EMPTY_FLAG_N)
      else $error("almost empty high with nothing to read");
endmodule
bind fopc_core fopc_core_sva i_fopc_core_sva (.CLK, .SYS_RST, .MASTER_RESET_N,
   .PORT_A_CTRL, .PORT_B_CTRL, .PORT_A_DATA_OE, .PORT_B_DATA_OE, .WRITE_SIDE_FLAG,
   .READ_SIDE_FLAG, .ALMOST_EMPTY_FLAG_N, .ALMOST_FULL_FLAG_N, .MAIL_ONE_FULL_N,
   .MAIL_TWO_FULL_N);
`default_nettype wire

// ### testbench/fopc_host_model.sv
/*
 host on both ports: strobe cycles, master reset with configuration, serial shift.
 assumes callers enter each task 1 ns after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module fopc_host_model (
   input wire logic clk,
   output var fopc_pkg::fopc_port_ctrl_type a_ctrl,
   output var fopc_pkg::fopc_port_ctrl_type b_ctrl,
   output logic [fopc_pkg::DATA_W-1:0] a_data,
   output logic [fopc_pkg::DATA_W-1:0] b_data,
   output logic mrst_n,
   output logic preset_parallel_select_n,
   output logic fs_hi,
   output logic fs_lo,
   output logic ft_n
);
   import fopc_pkg::*;
   initial
   begin
      // deselected ports and unlatched mode pins are don't-care, so they idle at random
      a_ctrl = {1'h1, 3'($urandom)};
      b_ctrl = {1'h1, 3'($urandom)};
      a_data = DATA_W'({$urandom, $urandom});
      b_data = DATA_W'({$urandom, $urandom});
      mrst_n = 1'h0;
      {preset_parallel_select_n, fs_hi, fs_lo, ft_n} = 4'($urandom);
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // direction and mail select are left standing so the answer can be watched
   task automatic pa(input logic dir, input logic mb, input logic [DATA_W-1:0] d);
      a_ctrl = {1'h0, dir, 1'h1, mb};
      a_data = d;
      tick(1);
      a_ctrl.strobe = 1'h0;
      a_data = ~d; // released lines must not keep the old value
      tick(1); // a following call must not raise the strobe in the same step
   endtask
   task automatic pb(input logic dir, input logic mb, input logic [DATA_W-1:0] d);
      b_ctrl = {1'h0, dir, 1'h1, mb};
      b_data = d;
      tick(1);
      b_ctrl.strobe = 1'h0;
      b_data = ~d;
      tick(1);
   endtask
   task automatic mreset(input logic [2:0] cfg, input logic ft);
      mrst_n = 1'h0;
      {preset_parallel_select_n, fs_hi, fs_lo} = cfg;
      ft_n = ft;
      tick(5);
      mrst_n = 1'h1;
      tick(12); // pins held well past the release so the latch sees them
   endtask
   task automatic shift(input logic [19:0] bits);
      for (int i = 19; i >= 0; i--)
      begin
         fs_hi = 1'h0;
         fs_lo = bits[i];
         tick(1);
      end
      fs_hi = 1'h1;
      fs_lo = ~fs_lo;
   endtask
endmodule
`default_nettype wire
